// ### cfg_decoder.sv
/*
  decodes a configuration dword address onto a register of the group.
  assumes byte addresses, dword aligned; low two bits are ignored.
*/
`timescale 1ns/1ns
`default_nettype none
`include "uerr_consts.svh"
module cfg_decoder
  import uerr_pkg::*;
(
  input wire logic [11:0] addr,
  output reg_sel_type sel
);
  ////////////////////////////////////////////////////////////////////////
  // address to register select, unmapped gives none
  function automatic reg_sel_type decode(input logic [11:0] a);
    logic [11:0] d;
    d = {a[11:2], 2'b00};
    if (d == `OFS_CAP_HDR) return SEL_CAP;
    if (d == `OFS_STATUS) return SEL_STATUS;
    if (d == `OFS_MASK) return SEL_MASK;
    if (d == `OFS_SEV) return SEL_SEV;
    if (d == `OFS_ERR_CTL) return SEL_ERR_CTL;
    if (d >= `OFS_HLOG0 && d <= `OFS_HLOG3) return SEL_HLOG;
    return SEL_NONE;
  endfunction : decode

  always_comb begin
    sel = decode(addr);
  end
endmodule : cfg_decoder
`default_nettype wire

// ### err_sel_if.sv
/*
  interface between the register group and its error arbiter.
  assumes both ends run on the same clock; contents are combinational.
*/
`timescale 1ns/1ns
`default_nettype none
interface err_sel_if;
  logic [31:0] events; // qualified events this cycle
  logic [31:0] mask; // current mask bits
  logic [31:0] sev; // current severity bits
  logic [4:0] first_idx; // lowest unmasked event
  logic hit; // any unmasked event
  logic fatal; // any unmasked fatal event

  modport arb (input events, input mask, input sev, output first_idx, output hit, output fatal);
  modport top (output events, output mask, output sev, input first_idx, input hit, input fatal);
endinterface : err_sel_if
`default_nettype wire

// ### error_arbiter.sv
/*
  picks the lowest unmasked error of a cycle and classes the cycle's report.
  assumes qualified events, mask and severity arrive through err_sel_if.
*/
`timescale 1ns/1ns
`default_nettype none
module error_arbiter (
  err_sel_if.arb sel
);
  ////////////////////////////////////////////////////////////////////////
  // masked errors drop out here, so they neither log nor report
  always_comb begin
    logic [31:0] live;
    live = sel.events & ~sel.mask;
    sel.hit = |live;
    sel.fatal = |(live & sel.sev);
    sel.first_idx = 5'h0_0;
    // walk down so the lowest set bit wins
    for (int i = 31; i >= 0; i--) begin
      if (live[i]) begin
        sel.first_idx = 5'(i);
      end
    end
  end
endmodule : error_arbiter
`default_nettype wire

// ### rc_msg_sink.sv
/*
  passive model of the root complex that receives error messages.
  assumes msg_valid and msg_fatal are registered on ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module rc_msg_sink (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic msg_valid,
  input wire logic msg_fatal,
  output logic [15:0] fatal_cnt, // fatal messages seen
  output logic [15:0] nonfatal_cnt // non-fatal messages seen
);
  //////////////////////////////////////////////////////////////////////////////
  // counts survive reset, so the bench can total a whole run
  logic [15:0] fatal_q = 16'h0000; // fatal messages so far
  logic [15:0] nonfatal_q = 16'h0000; // non-fatal messages so far
  assign fatal_cnt = fatal_q;
  assign nonfatal_cnt = nonfatal_q;

  // sort each message by its class; unknown valid is not counted
  always @(posedge ref_clk) begin
    if (rst_b === 1'b1 && msg_valid === 1'b1) begin
      if (msg_fatal === 1'b1) begin
        fatal_q <= fatal_q + 16'h0001;
      end else begin
        nonfatal_q <= nonfatal_q + 16'h0001;
      end
    end
  end
endmodule : rc_msg_sink
`default_nettype wire

// ### uerr_consts.svh
/*
  constants of the uncorrectable error reporting register group: offsets,
  field positions, reset values and bit groups, all as macros.
  assumes it is included by bare name from the design files and the bench.
*/
// Summary of operation
// - capability header reads 0001h, 1h, next pointer
// - training error sets bit 0, sticky
// - data link protocol error sets bit 4
// - surprise down sets bit 5, downstream only
// - poisoned tlp received or generated sets 12
// - flow control 13, timeout 14, abort 15
// - unexpected completion 16, receiver overflow 17
// - malformed tlp 18, end-to-end crc 19
// - unsupported request sets bit 20
// - acs violation sets 21, downstream only
// - internal 22, multicast blocked 23, atomic 24
// - masked error: no header log, no message
// - masks reset zero except internal error
// - severity bit set means fatal report
// - severity resets fatal for listed errors
// - header log holds four big-endian dwords
// - first error pointer names first error
`ifndef UERR_CONSTS_SVH
`define UERR_CONSTS_SVH

// register byte offsets in configuration space
`define OFS_CAP_HDR 12'h100
`define OFS_STATUS 12'h104
`define OFS_MASK 12'h108
`define OFS_SEV 12'h10C
`define OFS_ERR_CTL 12'h118
`define OFS_HLOG0 12'h11C
`define OFS_HLOG3 12'h128

// capability header fields
`define CAP_ID 16'h0001
`define CAP_VER 4'h1
`define CAP_NEXT_DEF 12'h130

// implemented status, mask and severity bits
`define UE_VALID 32'h01FF_F031
// bits that exist only on downstream ports
`define UE_DOWN_ONLY 32'h0020_0020
// surprise down bit position
`define UE_SURPRISE_BIT 5
// reset values
`define MASK_RST 32'h0040_0000
`define SEV_RST_UP 32'h0046_2011
`define SEV_RST_DOWN 32'h0046_2031

`endif

// ### uerr_pkg.sv
/*
  types of the uncorrectable error reporting block.
  assumes uerr_consts.svh is on the include path.
*/
`default_nettype none
package uerr_pkg;

  // which register a configuration address selects
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_CAP,
    SEL_STATUS,
    SEL_MASK,
    SEL_SEV,
    SEL_ERR_CTL,
    SEL_HLOG
  } reg_sel_type;

  // whole state of the register group
  typedef struct packed {
    logic [31:0] status_q; // sticky error status
    logic [31:0] mask_q; // log and message suppress
    logic [31:0] sev_q; // 1 fatal, 0 non-fatal
    logic down_q; // port is downstream
    logic log_held_q; // header log holds an error
    logic [4:0] ptr_q; // first error pointer
    logic [127:0] hdr_q; // logged header, dword 0 on top
    logic ack_q; // config access done
    logic [31:0] rdata_q; // read data
    logic msg_valid_q; // error message pulse
    logic msg_fatal_q; // message class
  } state_type;

endpackage : uerr_pkg
`default_nettype wire

// ### uncorrectable_error_reporting.sv
/*
  uncorrectable error reporting registers of one switch port: capability
  header, write-one-to-clear status, mask, severity, first error pointer and
  header log, plus the error message toward the root complex.
  assumes synchronous inputs on ref_clk, one-cycle error event pulses with
  the offending header valid alongside, and a port-type strap held stable.
*/
`timescale 1ns/1ns
`default_nettype none
`include "uerr_consts.svh"
module uncorrectable_error_reporting
  import uerr_pkg::*;
#(
  parameter logic [11:0] NEXT_CAP_PTR = `CAP_NEXT_DEF // next capability
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic port_is_down, // strap: 1 downstream, 0 upstream
  input wire logic cfg_req, // config access strobe
  input wire logic cfg_we, // 1 write, 0 read
  input wire logic [11:0] cfg_addr, // byte address
  input wire logic [3:0] cfg_be, // byte enables
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack, // access done pulse
  output logic [31:0] cfg_rdata,
  input wire logic [31:0] err_event, // one pulse per error, by status bit
  input wire logic [127:0] err_header, // header of the erroring tlp
  output logic msg_valid, // error message pulse
  output logic msg_fatal, // 1 fatal, 0 non-fatal message
  output logic [4:0] first_err_ptr // first error pointer
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  state_type s_q; // registered state
  state_type s_d; // next state
  reg_sel_type sel; // decoded register
  logic [31:0] be_bits; // byte enables spread to bits
  logic [31:0] ev_q; // qualified events
  logic wr; // write access this cycle
  logic rd; // read access this cycle
  err_sel_if arb_if ();

  ////////////////////////////////////////////////////////////////////////
  // sub-blocks
  cfg_decoder u_dec (
    .addr (cfg_addr),
    .sel (sel)
  );

  error_arbiter u_arb (
    .sel (arb_if)
  );

  ////////////////////////////////////////////////////////////////////////
  // event qualification: downstream-only bits vanish on the upstream port
  always_comb begin
    ev_q = err_event & `UE_VALID;
    if (!s_q.down_q) begin
      ev_q = ev_q & ~`UE_DOWN_ONLY;
    end
  end

  assign arb_if.events = ev_q;
  assign arb_if.mask = s_q.mask_q;
  assign arb_if.sev = s_q.sev_q;

  // byte enables to a bit mask
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_be
      assign be_bits[g*8 +: 8] = {8{cfg_be[g]}};
    end
  endgenerate

  assign wr = cfg_req & cfg_we;
  assign rd = cfg_req & ~cfg_we;

  ////////////////////////////////////////////////////////////////////////
  // next-state logic for the whole group
  always_comb begin
    logic [31:0] clr; // status bits software clears
    logic [31:0] wmask; // writable bits under this write
    logic [1:0] dw; // header log dword index
    s_d = s_q;
    clr = 32'h0000_0000;
    wmask = be_bits & `UE_VALID;
    dw = 2'(cfg_addr[3:2] - 2'b11); // 11c maps to 0
    // config writes; wmask keeps reserved bits out of every register,
    // so they read zero whatever software writes there
    // the capability header, pointer and log take no write at all
    if (wr && sel == SEL_STATUS) begin
      // only ones clear; zeros leave pending errors alone
      clr = cfg_wdata & wmask;
    end
    if (wr && sel == SEL_MASK) begin
      s_d.mask_q = (s_q.mask_q & ~wmask) | (cfg_wdata & wmask);
    end
    if (wr && sel == SEL_SEV) begin
      s_d.sev_q = (s_q.sev_q & ~wmask) | (cfg_wdata & wmask);
    end
    // set wins over a clear in the same cycle
    s_d.status_q = (s_q.status_q & ~clr) | ev_q;
    // header log frees once its error's status bit is gone
    if (s_q.log_held_q && !s_d.status_q[s_q.ptr_q]) begin
      s_d.log_held_q = 1'b0;
    end
    // capture only unmasked errors, and only into a free log
    if (arb_if.hit && !s_d.log_held_q) begin
      s_d.log_held_q = 1'b1;
      s_d.ptr_q = arb_if.first_idx;
      s_d.hdr_q = err_header;
    end
    // one message per cycle with unmasked errors, fatal dominates
    s_d.msg_valid_q = arb_if.hit;
    s_d.msg_fatal_q = arb_if.fatal;
    // access answer, one cycle later
    s_d.ack_q = cfg_req;
    s_d.rdata_q = 32'h0000_0000;
    if (rd) begin
      case (sel)
        SEL_CAP: s_d.rdata_q = {NEXT_CAP_PTR, `CAP_VER, `CAP_ID};
        SEL_STATUS: s_d.rdata_q = s_q.status_q;
        SEL_MASK: s_d.rdata_q = s_q.mask_q;
        SEL_SEV: s_d.rdata_q = s_q.sev_q;
        SEL_ERR_CTL: s_d.rdata_q = {27'h000_0000, s_q.ptr_q};
        SEL_HLOG: s_d.rdata_q = s_q.hdr_q[(3 - dw)*32 +: 32];
        default: s_d.rdata_q = 32'h0000_0000; // unmapped reads zero
      endcase
    end
    // synchronous reset; the strap is sampled while reset is held
    if (!rst_b) begin
      s_d = '0;
      s_d.down_q = port_is_down;
      s_d.mask_q = `MASK_RST;
      s_d.sev_q = port_is_down ? `SEV_RST_DOWN : `SEV_RST_UP;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge ref_clk) begin
    s_q <= s_d;
  end

  // outputs straight from state flops
  assign cfg_ack = s_q.ack_q;
  assign cfg_rdata = s_q.rdata_q;
  assign msg_valid = s_q.msg_valid_q;
  assign msg_fatal = s_q.msg_fatal_q;
  assign first_err_ptr = s_q.ptr_q;

  ////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // helper: qualified events that survive the mask this cycle
  logic [31:0] ev_unmasked;
  assign ev_unmasked = ev_q & ~s_q.mask_q;

  a_cap_header: assert property (
    (rd && sel == SEL_CAP) |=> cfg_ack && cfg_rdata == {NEXT_CAP_PTR, `CAP_VER, `CAP_ID})
    else $error("capability header read wrong");

  a_train_sticky: assert property (
    err_event[0] |=> s_q.status_q[0] ##1 (s_q.status_q[0] || $past(wr && sel == SEL_STATUS)))
    else $error("training error status not set or lost");

  a_status_sets: assert property (
    ((err_event & `UE_VALID & ~`UE_DOWN_ONLY) != 32'h0000_0000)
      |=> ((s_q.status_q & $past(err_event & `UE_VALID & ~`UE_DOWN_ONLY))
           == $past(err_event & `UE_VALID & ~`UE_DOWN_ONLY)))
    else $error("error event did not set its status bit");

  a_down_only: assert property (
    !s_q.down_q |-> (s_q.status_q & `UE_DOWN_ONLY) == 32'h0000_0000)
    else $error("downstream-only status set on upstream port");

  a_masked_quiet: assert property (
    (ev_q != 32'h0000_0000 && ev_unmasked == 32'h0000_0000) |=> !msg_valid)
    else $error("message sent for masked error");

  a_msg_class: assert property (
    (ev_unmasked != 32'h0000_0000)
      |=> msg_valid && msg_fatal == $past((ev_unmasked & s_q.sev_q) != 32'h0000_0000))
    else $error("message class disagrees with severity");

  a_reset_values: assert property (@(posedge ref_clk) disable iff (1'b0)
    $rose(rst_b) |-> s_q.mask_q == `MASK_RST
      && s_q.sev_q == (s_q.down_q ? `SEV_RST_DOWN : `SEV_RST_UP)
      && s_q.status_q == 32'h0000_0000)
    else $error("reset values of mask or severity wrong");

  a_log_capture: assert property (
    (ev_unmasked != 32'h0000_0000 && !s_q.log_held_q)
      |=> s_q.log_held_q && s_q.hdr_q == $past(err_header) && s_q.status_q[first_err_ptr])
    else $error("header log or first error pointer not captured");

  a_log_frozen: assert property (
    (s_q.log_held_q && s_q.status_q[s_q.ptr_q] && !wr) |=> $stable(s_q.hdr_q))
    else $error("held header log overwritten");

  a_w1c_keep: assert property (
    (wr && sel == SEL_STATUS && ev_q == 32'h0000_0000)
      |=> s_q.status_q == ($past(s_q.status_q) & ~($past(cfg_wdata & be_bits)))
          && (s_q.status_q & ~`UE_VALID) == 32'h0000_0000)
    else $error("write-one-to-clear behaviour wrong");

  // the pointer names the lowest unmasked error of its capture cycle
  a_first_lowest: assert property (
    (ev_unmasked != 32'h0000_0000 && !s_q.log_held_q)
      |=> ((($past(ev_unmasked) >> first_err_ptr) & 32'h0000_0001) == 32'h0000_0001)
          && (($past(ev_unmasked) & ((32'h0000_0001 << first_err_ptr) - 32'h0000_0001))
              == 32'h0000_0000))
    else $error("first error pointer is not the lowest unmasked error");

  // a held log keeps its pointer until its status bit goes
  a_ptr_hold: assert property (
    (s_q.log_held_q && s_q.status_q[s_q.ptr_q] && !wr) |=> $stable(first_err_ptr))
    else $error("first error pointer moved while its error is pending");

  // the pointer register reads back the pointer of the read cycle
  a_ptr_read: assert property (
    (rd && sel == SEL_ERR_CTL) |=> cfg_rdata == {27'h000_0000, $past(s_q.ptr_q)})
    else $error("first error pointer read wrong");

  // the first log dword is the top of the header, big-endian
  a_hlog_first: assert property (
    (rd && sel == SEL_HLOG && cfg_addr[3:2] == 2'b11) |=> cfg_rdata == $past(s_q.hdr_q[127:96]))
    else $error("first header log dword read wrong");

  // mask takes only enabled lanes of implemented bits
  a_mask_write: assert property (
    (wr && sel == SEL_MASK)
      |=> s_q.mask_q == (($past(s_q.mask_q) & ~$past(be_bits & `UE_VALID))
                         | $past(cfg_wdata & be_bits & `UE_VALID)))
    else $error("mask write did not land");

  // severity takes only enabled lanes of implemented bits
  a_sev_write: assert property (
    (wr && sel == SEL_SEV)
      |=> s_q.sev_q == (($past(s_q.sev_q) & ~$past(be_bits & `UE_VALID))
                        | $past(cfg_wdata & be_bits & `UE_VALID)))
    else $error("severity write did not land");

  // a status bit only ever rises on a qualified event
  a_status_source: assert property (
    1'b1 |=> ((s_q.status_q & ~$past(s_q.status_q) & ~$past(ev_q)) == 32'h0000_0000))
    else $error("status bit set without its event");

  // reserved bits of the three writable registers stay zero
  a_reserved_zero: assert property (
    ((s_q.status_q | s_q.mask_q | s_q.sev_q) & ~`UE_VALID) == 32'h0000_0000)
    else $error("reserved bit of status, mask or severity set");

  // unmapped reads answer with zero data
  a_unmapped_zero: assert property (
    (rd && sel == SEL_NONE) |=> cfg_ack && cfg_rdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  // every message has an unmasked error behind it
  a_msg_cause: assert property (
    msg_valid |-> $past(ev_unmasked) != 32'h0000_0000)
    else $error("message without an unmasked error");

  c_fatal_msg: cover property (msg_valid && msg_fatal);
  c_nonfatal_msg: cover property (msg_valid && !msg_fatal);
  c_clear_collide: cover property (wr && sel == SEL_STATUS && (ev_q & cfg_wdata) != 32'h0000_0000);
  c_log_reuse: cover property (s_q.log_held_q ##1 !s_q.log_held_q ##[1:20] s_q.log_held_q);
  c_masked_event: cover property (ev_q != 32'h0000_0000 && ev_unmasked == 32'h0000_0000);

endmodule : uncorrectable_error_reporting
`default_nettype wire

// ### uncorrectable_error_reporting_tb_top.sv
/*
  self-checking bench of the uncorrectable error register group.
  assumes uerr_consts.svh on the include path; inputs move on falling edges.
*/
`timescale 1ns/1ns
`default_nettype none
`include "uerr_consts.svh"
module uncorrectable_error_reporting_tb_top;
  localparam logic [31:0] valid_bits = `UE_VALID; // implemented bits
  localparam logic [31:0] down_bits = `UE_DOWN_ONLY; // downstream only
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic port_is_down = 1'b0;
  logic cfg_req = 1'b0;
  logic cfg_we = 1'b0;
  logic [11:0] cfg_addr = 12'h000;
  logic [3:0] cfg_be = 4'hF;
  logic [31:0] cfg_wdata = 32'h0000_0000;
  logic cfg_ack;
  logic [31:0] cfg_rdata;
  logic [31:0] err_event = 32'h0000_0000;
  logic [127:0] err_header = 128'h0;
  logic msg_valid;
  logic msg_fatal;
  logic [4:0] first_err_ptr;
  logic [15:0] fatal_cnt;
  logic [15:0] nonfatal_cnt;
  logic [31:0] mask_e; // expected mask
  logic [31:0] sev_e; // expected severity
  logic [4:0] ptr_e; // expected first error pointer
  int fatal_e = 0;
  int nonfatal_e = 0;
  int err_total = 0;
  int check_count = 0;

  //////////////////////////////////////////////////////////////////////////////
  always #10 ref_clk = ~ref_clk; // 50 MHz

  uncorrectable_error_reporting u_uncorrectable_error_reporting (
    .ref_clk(ref_clk), .rst_b(rst_b), .port_is_down(port_is_down),
    .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .err_event(err_event), .err_header(err_header), .msg_valid(msg_valid),
    .msg_fatal(msg_fatal), .first_err_ptr(first_err_ptr));

  rc_msg_sink u_rc_msg_sink (
    .ref_clk(ref_clk), .rst_b(rst_b), .msg_valid(msg_valid),
    .msg_fatal(msg_fatal), .fatal_cnt(fatal_cnt), .nonfatal_cnt(nonfatal_cnt));

  //////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one config access; the answer is due exactly one cycle later
  task automatic acc(input logic we, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rv);
    @(negedge ref_clk);
    cfg_req = 1'b1;
    cfg_we = we;
    cfg_addr = a;
    cfg_wdata = wd;
    @(negedge ref_clk);
    cfg_req = 1'b0;
    check(32'(cfg_ack), 32'h0000_0001);
    rv = cfg_rdata;
  endtask : acc

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] v;
    acc(1'b0, a, 32'h0000_0000, v);
    check(v, exp);
  endtask : rd

  // writes return zero data
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] v;
    acc(1'b1, a, d, v);
    check(v, 32'h0000_0000);
  endtask : wr

  task automatic do_reset(input logic down);
    @(negedge ref_clk);
    rst_b = 1'b0;
    port_is_down = down;
    repeat (4) @(negedge ref_clk);
    rst_b = 1'b1;
    mask_e = `MASK_RST;
    sev_e = down ? `SEV_RST_DOWN : `SEV_RST_UP;
    ptr_e = 5'h00;
  endtask : do_reset

  // raise one event, check message, status, pointer, log, then clear it
  task automatic hit(input int i);
    logic set;
    logic msg;
    logic [127:0] h;
    logic [31:0] st;
    set = valid_bits[i] && (port_is_down || !down_bits[i]);
    msg = set && !mask_e[i];
    h = {4{32'(i)}} ^ 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
    st = set ? (32'h0000_0001 << i) : 32'h0000_0000;
    @(negedge ref_clk);
    err_event = 32'h0000_0001 << i;
    err_header = h;
    @(negedge ref_clk);
    err_event = 32'h0000_0000;
    check(32'(msg_valid), 32'(msg));
    if (msg) begin
      check(32'(msg_fatal), 32'(sev_e[i]));
      if (sev_e[i]) fatal_e++;
      else nonfatal_e++;
      ptr_e = 5'(i);
    end
    check(32'(first_err_ptr), 32'(ptr_e));
    rd(`OFS_ERR_CTL, 32'(ptr_e));
    rd(`OFS_STATUS, st);
    for (int k = 0; k < 4 && msg; k++) begin
      rd(`OFS_HLOG0 + 12'(4 * k), h[127 - 32 * k -: 32]);
    end
    wr(`OFS_STATUS, 32'h0000_0000);
    rd(`OFS_STATUS, st);
    wr(`OFS_STATUS, 32'h0000_0001 << i);
    rd(`OFS_STATUS, 32'h0000_0000);
  endtask : hit

  task automatic sweep;
    for (int i = 0; i < 25; i++) hit(i);
  endtask : sweep

  //////////////////////////////////////////////////////////////////////////////
  // bound on the whole run in case the design stalls
  initial begin
    #1_000_000;
    err_total++;
    end_sim();
  end

  initial begin
    do_reset(1'b0);
    rd(`OFS_CAP_HDR, {`CAP_NEXT_DEF, `CAP_VER, `CAP_ID});
    wr(`OFS_CAP_HDR, 32'hFFFF_FFFF);
    rd(`OFS_CAP_HDR, {`CAP_NEXT_DEF, `CAP_VER, `CAP_ID});
    rd(`OFS_STATUS, 32'h0000_0000);
    rd(`OFS_MASK, 32'h0040_0000);
    rd(`OFS_SEV, 32'h0046_2011);
    rd(12'h200, 32'h0000_0000);
    sweep();
    do_reset(1'b1);
    rd(`OFS_SEV, 32'h0046_2031);
    sweep();
    wr(`OFS_MASK, 32'hFFFF_FFFF);
    wr(`OFS_SEV, 32'h0000_0000);
    mask_e = valid_bits;
    sev_e = 32'h0000_0000;
    rd(`OFS_MASK, valid_bits);
    sweep();
    wr(`OFS_MASK, 32'h0000_0000);
    wr(`OFS_SEV, 32'hFFFF_FFFF);
    mask_e = 32'h0000_0000;
    sev_e = valid_bits;
    rd(`OFS_SEV, valid_bits);
    sweep();
    cfg_be = 4'h4; // only the third byte lane may change
    wr(`OFS_MASK, 32'hFFFF_FFFF);
    cfg_be = 4'hF;
    rd(`OFS_MASK, 32'h00FF_0000);
    @(negedge ref_clk);
    check(32'(fatal_cnt), 32'(fatal_e));
    check(32'(nonfatal_cnt), 32'(nonfatal_e));
    end_sim();
  end
endmodule : uncorrectable_error_reporting_tb_top
`default_nettype wire
